/* rtl/ntm_pkg.sv */
// Package with register map, field layouts and timing constants of the protocol timers.
package ntm_pkg;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MRT = 8'h04;
    localparam logic [7:0] ADDR_NRT = 8'h08;
    localparam logic [7:0] ADDR_GPT = 8'h0C;
    localparam logic [7:0] ADDR_WUT = 8'h10;
    localparam logic [7:0] ADDR_CMD = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // ==========================================================
    // Timer steps, held as the last prescaler value of one step (fc cycles minus one)
    localparam logic [11:0] MRT_STEP_LAST = 12'h03F;
    localparam logic [11:0] MRT_LP_STEP_LAST = 12'h1FF;
    localparam logic [11:0] NRT_FINE_STEP_LAST = 12'h03F;
    localparam logic [11:0] NRT_COARSE_STEP_LAST = 12'hFFF;
    localparam logic [11:0] GPT_STEP_LAST = 12'h007;

    // ==========================================================
    // Wake-up timer: periods in ms, RC oscillator ticks per ms
    localparam logic [14:0] RC_TICKS_PER_MS = 15'h0020;
    localparam logic [2:0] WUT_SEL_RESET = 3'h3;
    localparam logic [9:0] WUT_PERIOD_MS [8] = '{
        10'h00A, 10'h014, 10'h032, 10'h064, 10'h0C8, 10'h190, 10'h258, 10'h320
    };

    // ==========================================================
    // Field layouts
    typedef enum logic [1:0] {
        GPT_TRIG_NONE,
        GPT_TRIG_SOF,
        GPT_TRIG_EOF,
        GPT_TRIG_FIELD_OFF
    } ntm_gpt_trig_type;

    typedef struct packed {
        logic wakeup_mode;
        logic lp_target;
        logic nfc_active;
        logic squelch_en;
        logic nrt_uncond;
        logic nrt_step;
        ntm_gpt_trig_type gpt_trig;
    } ntm_ctrl_type;

    typedef struct packed {
        logic start_wut;
        logic start_gpt;
        logic start_nrt;
        logic start_mrt;
        logic clear;
    } ntm_cmd_type;

    typedef struct packed {
        logic rx_enable;
        logic wut_run;
        logic gpt_run;
        logic nrt_run;
        logic mrt_run;
        logic wakeup_timer_flag;
        logic gpt_flag;
        logic nre_flag;
    } ntm_status_type;

    typedef struct packed {
        logic tx_end;
        logic rx_sof;
        logic rx_eof;
        logic reply_active;
        logic peer_field_on;
        logic peer_field_off;
    } ntm_frame_ev_type;

    typedef struct packed {
        logic run;
        logic [11:0] pre;
        logic [15:0] cnt;
    } ntm_timer_type;

    typedef struct packed {
        ntm_ctrl_type ctrl;
        logic [7:0] mrt_val;
        logic [15:0] nrt_val;
        logic [15:0] gpt_val;
        logic [2:0] wut_sel;
        ntm_timer_type mrt;
        ntm_timer_type nrt;
        ntm_timer_type gpt;
        logic wut_run;
        logic [14:0] wut_cnt;
        logic nre_flag;
        logic gpt_flag;
        logic wakeup_timer_flag;
        logic force_low;
        logic rx_enable;
        logic squelch_on;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } ntm_state_type;

endpackage

/* rtl/ntm_timers.sv */
// Protocol timers (mask-receive, no-response, general-purpose, wake-up) with APB registers.
//
// Operation
// - Clear stops all but wake-up, unconditional no-response.
// - End of transmission starts mask and no-response.
// - Receive enable low while mask timer runs.
// - Squelch on while mask timer runs, if enabled.
// - Mask timer expiry raises no flag.
// - Active mode: peer field on starts mask timer.
// - Low-power target: command start, step 512/fc.
// - No-response step 64/fc or 4096/fc.
// - Mode clear: timeout flags, blocks receive; reply stops.
// - Mode set: always flag; block receive if idle.
// - No-response start command restarts a running timer.
// - Active mode ignores no-response start command.
// - Active mode: flag if field absent at expiry.
// - No-response timeout sets its own flag.
// - General timer triggers on SOF, EOF, field off; the field-off trigger acts in active mode only.
// - General start command restarts a running timer.
// - Wake-up start command, rejected in wake-up mode.
// - Carrier timers on fc, wake-up timer on RC.
// - Wake-up period 10 to 800 ms, default 100.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module ntm_timers (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic fc_tick,
    input wire logic rc_tick,
    input wire ntm_pkg::ntm_frame_ev_type frame_ev,
    output logic rx_enable,
    output logic squelch_on,
    output logic rc_osc_en
);

    // ==========================================================
    // Helpers

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == ntm_pkg::ADDR_CTRL) || (a == ntm_pkg::ADDR_MRT)
            || (a == ntm_pkg::ADDR_NRT) || (a == ntm_pkg::ADDR_GPT)
            || (a == ntm_pkg::ADDR_WUT) || (a == ntm_pkg::ADDR_CMD)
            || (a == ntm_pkg::ADDR_STATUS);
    endfunction

    // True when the running timer completes its last step on this fc tick.
    function automatic logic step_done(
        input ntm_pkg::ntm_timer_type t,
        input logic [11:0] last,
        input logic [15:0] limit,
        input logic tick
    );
        step_done = t.run && tick && (t.pre == last) && ((t.cnt + 16'h0001) == limit);
    endfunction

    function automatic ntm_pkg::ntm_timer_type advance(
        input ntm_pkg::ntm_timer_type t,
        input logic [11:0] last,
        input logic tick
    );
        ntm_pkg::ntm_timer_type r;
        r = t;
        if (t.run && tick) begin
            if (t.pre == last) begin
                r.pre = 12'h000;
                r.cnt = t.cnt + 16'h0001;
            end else begin
                r.pre = t.pre + 12'h001;
            end
        end
        advance = r;
    endfunction

    function automatic ntm_pkg::ntm_timer_type started();
        ntm_pkg::ntm_timer_type r;
        r = '0;
        r.run = 1'b1;
        started = r;
    endfunction

    // ==========================================================
    // State

    ntm_pkg::ntm_state_type s;
    ntm_pkg::ntm_state_type next_s;

    always_comb begin
        ntm_pkg::ntm_cmd_type cmd;
        ntm_pkg::ntm_status_type st;
        ntm_pkg::ntm_status_type clr;
        logic access;
        logic [11:0] mrt_last;
        logic [11:0] nrt_last;
        logic [15:0] mrt_limit;
        logic mrt_exp;
        logic nrt_exp;
        logic gpt_exp;
        logic wut_exp;
        logic set_nre;
        logic start_mrt;
        logic start_nrt;
        logic start_gpt;
        logic [14:0] wut_limit;
        st = '0;
        access = 1'b0;
        mrt_last = 12'h000;
        nrt_last = 12'h000;
        mrt_limit = 16'h0000;
        mrt_exp = 1'b0;
        nrt_exp = 1'b0;
        gpt_exp = 1'b0;
        wut_exp = 1'b0;
        start_mrt = 1'b0;
        start_nrt = 1'b0;
        start_gpt = 1'b0;
        wut_limit = 15'h0000;
        next_s = s;
        cmd = '0;
        clr = '0;
        set_nre = 1'b0;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;

        // ======================================================
        // APB slave: one wait-free access phase after each setup.
        st.rx_enable = s.rx_enable;
        st.wut_run = s.wut_run;
        st.gpt_run = s.gpt.run;
        st.nrt_run = s.nrt.run;
        st.mrt_run = s.mrt.run;
        st.wakeup_timer_flag = s.wakeup_timer_flag;
        st.gpt_flag = s.gpt_flag;
        st.nre_flag = s.nre_flag;
        if (psel && !penable) begin
            next_s.pready = 1'b1;
            next_s.pslverr = !addr_ok(paddr);
            unique case (paddr)
                ntm_pkg::ADDR_CTRL: next_s.prdata = {24'h000000, s.ctrl};
                ntm_pkg::ADDR_MRT: next_s.prdata = {24'h000000, s.mrt_val};
                ntm_pkg::ADDR_NRT: next_s.prdata = {16'h0000, s.nrt_val};
                ntm_pkg::ADDR_GPT: next_s.prdata = {16'h0000, s.gpt_val};
                ntm_pkg::ADDR_WUT: next_s.prdata = {29'h00000000, s.wut_sel};
                ntm_pkg::ADDR_STATUS: next_s.prdata = {24'h000000, st};
                default: next_s.prdata = 32'h00000000;
            endcase
        end
        access = psel && penable && s.pready && pwrite && !s.pslverr;
        if (access) begin
            unique case (paddr)
                ntm_pkg::ADDR_CTRL: next_s.ctrl = ntm_pkg::ntm_ctrl_type'(pwdata[7:0]);
                ntm_pkg::ADDR_MRT: next_s.mrt_val = pwdata[7:0];
                ntm_pkg::ADDR_NRT: next_s.nrt_val = pwdata[15:0];
                ntm_pkg::ADDR_GPT: next_s.gpt_val = pwdata[15:0];
                ntm_pkg::ADDR_WUT: next_s.wut_sel = pwdata[2:0];
                ntm_pkg::ADDR_CMD: cmd = ntm_pkg::ntm_cmd_type'(pwdata[4:0]);
                ntm_pkg::ADDR_STATUS: clr = ntm_pkg::ntm_status_type'(pwdata[7:0]);
                default: cmd = '0;
            endcase
        end

        // ======================================================
        // Mask-receive timer. Its expiry only reopens the receiver and turns squelch off.
        mrt_last = s.ctrl.lp_target ? ntm_pkg::MRT_LP_STEP_LAST : ntm_pkg::MRT_STEP_LAST;
        mrt_limit = {8'h00, s.mrt_val};
        mrt_exp = step_done(s.mrt, mrt_last, mrt_limit, fc_tick);
        next_s.mrt = advance(s.mrt, mrt_last, fc_tick);
        if (mrt_exp) begin
            next_s.mrt.run = 1'b0;
        end
        start_mrt = frame_ev.tx_end
            || (s.ctrl.nfc_active && frame_ev.peer_field_on)
            || cmd.start_mrt;
        if (start_mrt && (s.mrt_val != 8'h00)) begin
            next_s.mrt = started();
        end
        if (cmd.clear) begin
            next_s.mrt.run = 1'b0;
        end

        // ======================================================
        // No-response timer.
        nrt_last = s.ctrl.nrt_step ? ntm_pkg::NRT_COARSE_STEP_LAST
            : ntm_pkg::NRT_FINE_STEP_LAST;
        nrt_exp = step_done(s.nrt, nrt_last, s.nrt_val, fc_tick);
        next_s.nrt = advance(s.nrt, nrt_last, fc_tick);
        if (frame_ev.tx_end) begin
            next_s.force_low = 1'b0;
        end
        if (nrt_exp) begin
            next_s.nrt.run = 1'b0;
            set_nre = 1'b1;
            if (s.ctrl.nfc_active) begin
                set_nre = 1'b1;
            end else if (!s.ctrl.nrt_uncond || !frame_ev.reply_active) begin
                next_s.force_low = 1'b1;
            end
        end
        if (s.ctrl.nfc_active && frame_ev.peer_field_on) begin
            next_s.nrt.run = 1'b0;
        end
        if (!s.ctrl.nfc_active && !s.ctrl.nrt_uncond && frame_ev.rx_sof && !nrt_exp) begin
            next_s.nrt.run = 1'b0;
        end
        start_nrt = frame_ev.tx_end
            || (cmd.start_nrt && !s.ctrl.nfc_active);
        if (start_nrt && (s.nrt_val != 16'h0000)) begin
            next_s.nrt = started();
        end
        if (cmd.clear && !s.ctrl.nrt_uncond) begin
            next_s.nrt.run = 1'b0;
        end

        // ======================================================
        // General-purpose timer.
        gpt_exp = step_done(s.gpt, ntm_pkg::GPT_STEP_LAST, s.gpt_val, fc_tick);
        next_s.gpt = advance(s.gpt, ntm_pkg::GPT_STEP_LAST, fc_tick);
        if (gpt_exp) begin
            next_s.gpt.run = 1'b0;
        end
        unique case (s.ctrl.gpt_trig)
            ntm_pkg::GPT_TRIG_SOF: start_gpt = frame_ev.rx_sof;
            ntm_pkg::GPT_TRIG_EOF: start_gpt = frame_ev.rx_eof;
            ntm_pkg::GPT_TRIG_FIELD_OFF:
                start_gpt = s.ctrl.nfc_active && frame_ev.peer_field_off;
            ntm_pkg::GPT_TRIG_NONE: start_gpt = 1'b0;
        endcase
        if ((start_gpt || cmd.start_gpt) && (s.gpt_val != 16'h0000)) begin
            next_s.gpt = started();
        end
        if (cmd.clear) begin
            next_s.gpt.run = 1'b0;
        end

        // ======================================================
        // Wake-up timer on RC ticks; in wake-up mode it repeats by itself.
        wut_limit = 15'(WUT_PERIOD_MS_SEL(s.wut_sel) * ntm_pkg::RC_TICKS_PER_MS);
        wut_exp = s.wut_run && rc_tick && ((s.wut_cnt + 15'h0001) == wut_limit);
        if (s.wut_run && rc_tick) begin
            next_s.wut_cnt = wut_exp ? 15'h0000 : s.wut_cnt + 15'h0001;
        end
        if (wut_exp) begin
            next_s.wut_run = s.ctrl.wakeup_mode;
        end
        if (cmd.start_wut && !s.ctrl.wakeup_mode) begin
            next_s.wut_run = 1'b1;
            next_s.wut_cnt = 15'h0000;
        end

        // ======================================================
        // Flags: a set in the clearing cycle wins.
        next_s.nre_flag = (s.nre_flag && !clr.nre_flag) || set_nre;
        next_s.gpt_flag = (s.gpt_flag && !clr.gpt_flag) || gpt_exp;
        next_s.wakeup_timer_flag = (s.wakeup_timer_flag && !clr.wakeup_timer_flag)
            || wut_exp;

        // ======================================================
        // Receiver gating outputs.
        next_s.rx_enable = !next_s.mrt.run && !next_s.force_low;
        next_s.squelch_on = s.ctrl.squelch_en && next_s.mrt.run;
    end

    // Period lookup kept as a function so the table stays in the package.
    function automatic logic [14:0] WUT_PERIOD_MS_SEL(input logic [2:0] sel);
        WUT_PERIOD_MS_SEL = {5'h00, ntm_pkg::WUT_PERIOD_MS[sel]};
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.wut_sel <= ntm_pkg::WUT_SEL_RESET;
            s.rx_enable <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign pready = s.pready;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    assign rx_enable = s.rx_enable;
    assign squelch_on = s.squelch_on;
    assign rc_osc_en = s.wut_run;

endmodule // ntm_timers

/* testbench/ntm_timers_sva.sv */
// Port-level assertions for the protocol timer block.
`timescale 1ns/1ps
module ntm_timers_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic rc_tick,
    input wire logic rx_enable,
    input wire logic squelch_on,
    input wire logic rc_osc_en
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Wake-up run length in RC ticks.
    logic [15:0] wake_ticks;
    logic wake_mode;
    logic wake_wr;
    // A start command is refused in wake-up mode, so the mode bit is tracked from CTRL writes.
    assign wake_wr = psel && penable && pready && pwrite && !pslverr
        && paddr == ntm_pkg::ADDR_CMD && pwdata[4] && !wake_mode;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_mode <= 1'b0;
        end else if (psel && penable && pready && pwrite && !pslverr
            && paddr == ntm_pkg::ADDR_CTRL) begin
            wake_mode <= pwdata[7];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_ticks <= 16'h0000;
        end else if (!rc_osc_en || wake_wr) begin
            wake_ticks <= 16'h0000;
        end else if (rc_tick) begin
            wake_ticks <= wake_ticks + 16'h0001;
        end
    end
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence wake_cmd;
        wake_wr;
    endsequence
    chk_ready_setup: assert property (apb_setup |=> pready)
        else $error("pready missing after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    chk_err_decode: assert property (pready && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > ntm_pkg::ADDR_STATUS))
        else $error("pslverr decode wrong");
    chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response carries data");
    chk_squelch_mask: assert property (squelch_on |-> !rx_enable)
        else $error("squelch on while receive enabled");
    chk_wake_start: assert property (wake_cmd |=> rc_osc_en)
        else $error("wake-up start ignored");
    chk_wake_span: assert property ($fell(rc_osc_en)
        |-> $past(wake_ticks) >= 16'h013E && $past(wake_ticks) <= 16'h6402)
        else $error("wake-up period out of range");
endmodule // ntm_timers_sva

/* testbench/ntm_frontend.sv */
// Model of the framing logic and the two oscillators feeding the timers.
`timescale 1ns/1ps
module ntm_frontend (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire ntm_pkg::ntm_frame_ev_type ev_req,
    output ntm_pkg::ntm_frame_ev_type frame_ev,
    output logic fc_tick,
    output logic rc_tick
);
    // ==========================================================
    // Carrier ticks each cycle, or every second one when slow.
    logic ph;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph <= 1'b0;
            fc_tick <= 1'b0;
            frame_ev <= '0;
        end else begin
            ph <= ~ph;
            fc_tick <= !slow || ph;
            frame_ev <= ev_req;
        end
    end
    // The RC oscillator ticks every second cycle, slower than the carrier unless slow is set.
    assign rc_tick = ph;
endmodule // ntm_frontend

/* testbench/ntm_timers_bench.sv */
// Self-checking bench of the protocol timer block.
`timescale 1ns/1ps
module ntm_timers_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic fc_tick, rc_tick, rx_enable, squelch_on, rc_osc_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [15:0] seed;
    ntm_pkg::ntm_frame_ev_type frame_ev, ev_req;
    logic [32:0] exp_q[$];
    logic [7:0] gctl [3] = '{8'h01, 8'h02, 8'h23};
    logic [5:0] gev [3] = '{6'h10, 6'h08, 6'h01};
    int err_count, cmp_count, n, c;
    ntm_timers u_ntm_timers (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .fc_tick, .rc_tick, .frame_ev, .rx_enable, .squelch_on,
        .rc_osc_en);
    ntm_frontend u_ntm_frontend (.pclk, .presetn, .slow, .ev_req, .frame_ev, .fc_tick,
        .rc_tick);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [32:0] e, input logic [32:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic st(input logic [32:0] e);
        rd(ntm_pkg::ADDR_STATUS, e);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge pclk);
        ev_req <= ntm_pkg::ntm_frame_ev_type'(ev_req | m);
        @(posedge pclk);
        ev_req <= ntm_pkg::ntm_frame_ev_type'(ev_req & ~m);
    endtask
    always @(posedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
            cmp("read", exp_q.pop_front(), {pslverr, prdata});
        end
    end
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        slow = 1'b0;
        ev_req = '0;
        seed = lfsr(16'h8425);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 24; a += 4) rd(8'(a), (a == 16) ? 33'h3 : 33'h0);
        st(33'h80);
        rd(8'h1C, 33'h100000000);
        // ==========================================================
        // Mask timer with a random count and a slowed carrier.
        v = {29'h0, seed[2:0]} + 32'h1;
        apb(1'b1, ntm_pkg::ADDR_CTRL, 32'h10);
        apb(1'b1, ntm_pkg::ADDR_MRT, v);
        rd(ntm_pkg::ADDR_MRT, {1'b0, v});
        slow <= 1'b1;
        pulse(6'h20);
        cyc(2);
        cmp("squelch_on", 33'h1, {32'h0, squelch_on});
        cmp("rx_enable", 33'h0, {32'h0, rx_enable});
        c = 0;
        while (rx_enable !== 1'b1 && c < 2000) begin
            cyc(1);
            c++;
        end
        if (c >= 2000) begin
            err_count++;
            end_of_test();
        end
        slow <= 1'b0;
        cmp("mask_len", 33'h1, {32'h0, c >= 128 * v - 4 && c <= 128 * v + 4});
        st(33'h80);
        // ==========================================================
        // No-response timer in both modes, with Clear and restart.
        apb(1'b1, ntm_pkg::ADDR_MRT, 32'h1);
        apb(1'b1, ntm_pkg::ADDR_NRT, 32'h2);
        pulse(6'h20);
        cyc(200);
        st(33'h01);
        apb(1'b1, ntm_pkg::ADDR_STATUS, 32'h1);
        pulse(6'h20);
        cyc(80);
        pulse(6'h10);
        cyc(150);
        st(33'h80);
        apb(1'b1, ntm_pkg::ADDR_CTRL, 32'h08);
        ev_req.reply_active <= 1'b1;
        pulse(6'h20);
        cyc(200);
        st(33'h81);
        ev_req.reply_active <= 1'b0;
        apb(1'b1, ntm_pkg::ADDR_STATUS, 32'h1);
        pulse(6'h20);
        cyc(3);
        apb(1'b1, ntm_pkg::ADDR_CMD, 32'h1);
        st(33'h90);
        cyc(200);
        st(33'h01);
        apb(1'b1, ntm_pkg::ADDR_STATUS, 32'h1);
        apb(1'b1, ntm_pkg::ADDR_CTRL, 32'h0);
        pulse(6'h20);
        cyc(3);
        apb(1'b1, ntm_pkg::ADDR_CMD, 32'h1);
        st(33'h80);
        apb(1'b1, ntm_pkg::ADDR_CMD, 32'h4);
        cyc(90);
        apb(1'b1, ntm_pkg::ADDR_CMD, 32'h4);
        cyc(90);
        st(33'h90);
        cyc(60);
        st(33'h01);
        apb(1'b1, ntm_pkg::ADDR_STATUS, 32'h1);
        apb(1'b1, ntm_pkg::ADDR_CTRL, 32'h04);
        apb(1'b1, ntm_pkg::ADDR_NRT, 32'h1);
        apb(1'b1, ntm_pkg::ADDR_CMD, 32'h4);
        cyc(3000);
        st(33'h10);
        cyc(1200);
        st(33'h01);
        apb(1'b1, ntm_pkg::ADDR_STATUS, 32'h1);
        apb(1'b1, ntm_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, ntm_pkg::ADDR_NRT, 32'h0);
        pulse(6'h20);
        cyc(80);
        apb(1'b1, ntm_pkg::ADDR_CMD, 32'h4);
        st(33'h80);
        apb(1'b1, ntm_pkg::ADDR_NRT, 32'h2);
        apb(1'b1, ntm_pkg::ADDR_CTRL, 32'h20);
        apb(1'b1, ntm_pkg::ADDR_CMD, 32'h4);
        st(33'h80);
        pulse(6'h02);
        cyc(2);
        cmp("rx_enable", 33'h0, {32'h0, rx_enable});
        cyc(80);
        pulse(6'h20);
        cyc(200);
        st(33'h81);
        apb(1'b1, ntm_pkg::ADDR_STATUS, 32'h1);
        // ==========================================================
        // General timer on each trigger, then restart by command.
        apb(1'b1, ntm_pkg::ADDR_GPT, 32'h3);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ntm_pkg::ADDR_CTRL, {24'h0, gctl[i]});
            pulse(gev[i]);
            cyc(30);
            st(33'h82);
            apb(1'b1, ntm_pkg::ADDR_STATUS, 32'h2);
        end
        apb(1'b1, ntm_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, ntm_pkg::ADDR_CMD, 32'h8);
        cyc(12);
        apb(1'b1, ntm_pkg::ADDR_CMD, 32'h8);
        cyc(12);
        st(33'hA0);
        cyc(20);
        st(33'h82);
        // ==========================================================
        // Low-power target mask step, then the wake-up timer.
        apb(1'b1, ntm_pkg::ADDR_CTRL, 32'h40);
        apb(1'b1, ntm_pkg::ADDR_CMD, 32'h2);
        cyc(450);
        cmp("rx_enable", 33'h0, {32'h0, rx_enable});
        cyc(80);
        cmp("rx_enable", 33'h1, {32'h0, rx_enable});
        apb(1'b1, ntm_pkg::ADDR_WUT, 32'h0);
        apb(1'b1, ntm_pkg::ADDR_CMD, 32'h11);
        cyc(2);
        cmp("rc_osc_en", 33'h1, {32'h0, rc_osc_en});
        cyc(600);
        cmp("rc_osc_en", 33'h1, {32'h0, rc_osc_en});
        cyc(50);
        cmp("rc_osc_en", 33'h0, {32'h0, rc_osc_en});
        st(33'h86);
        end_of_test();
    end
endmodule // ntm_timers_bench
bind ntm_timers ntm_timers_sva u_ntm_timers_sva (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .rc_tick, .rx_enable, .squelch_on, .rc_osc_en);
